// >>> logic/ser_defines.vh
`ifndef SER_DEFINES_VH
`define SER_DEFINES_VH
// command selector codes on cmd_sel
`define SER_SEL_OPER 3'h0
`define SER_SEL_TRIG 3'h1
`define SER_SEL_ARM 3'h2
`define SER_SEL_SEQ 3'h3
`define SER_SEL_ERRQ 3'h4
`define SER_SEL_PRESET 3'h5
`define SER_SEL_CLS 3'h6
// per-group operation codes on cmd_op
`define SER_OP_EV_RD 3'h0
`define SER_OP_EN_WR 3'h1
`define SER_OP_EN_RD 3'h2
`define SER_OP_RISE_WR 3'h3
`define SER_OP_RISE_RD 3'h4
`define SER_OP_FALL_WR 3'h5
`define SER_OP_FALL_RD 3'h6
`define SER_OP_COND_RD 3'h7
// error queue operation codes on cmd_op
`define SER_OP_Q_NEXT 3'h0
`define SER_OP_Q_ADMIT_WR 3'h1
`define SER_OP_Q_ADMIT_RD 3'h2
`define SER_OP_Q_EXCL_WR 3'h3
`define SER_OP_Q_EXCL_RD 3'h4
// operation group bit positions
`define SER_OPER_SETTLE_BIT 1
`define SER_OPER_FIRE_BIT 5
`define SER_OPER_ENABLE_BIT 6
`define SER_OPER_IDLE_BIT 10
// implemented-bit masks and reset values
`define SER_OPER_MASK 16'h0462
`define SER_FULL_MASK 16'hFFFF
`define SER_EVENT_RST 16'h0000
`define SER_ENABLE_RST 16'h0000
`define SER_FALL_RST 16'h0000
`define SER_ADMIT_RST 16'hFFFF
`define SER_EXCL_RST 16'h0000
`endif

// >>> logic/ser_errq.v
`default_nettype none
`include "ser_defines.vh"
module ser_errq #(
  parameter DEPTH = 8
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire err_valid,
  input wire [7:0] err_code,
  input wire cls,
  input wire preset,
  input wire sel,
  input wire [2:0] op,
  input wire [15:0] wdata,
  output wire [15:0] rdata,
  output wire empty
);

reg [7:0] slot_r [0:DEPTH-1];
reg [15:0] admit_r;
reg [15:0] excl_r;
reg [DEPTH-1:0] used_r;
wire [7:0] slot_nxt [0:DEPTH-1];
wire [DEPTH-1:0] used_nxt;
wire admitted;
wire pop;
wire push;
genvar gi;
integer si;

////////////////////////////////////////////////////////////////////////////////
// admission by low code nibble: exclusion wins over admission
assign admitted = admit_r[err_code[3:0]] & ~excl_r[err_code[3:0]];
assign push = err_valid & admitted;
assign pop = sel && op == `SER_OP_Q_NEXT && used_r[0];
assign empty = ~used_r[0];

// newest sits at slot 0; when full the oldest drops off the far end
generate
  for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_slot
    wire [7:0] newer;
    wire [7:0] older;
    wire newer_used;
    wire older_used;
    if (gi == 0) begin : g_head
      assign newer = err_code;
      assign newer_used = 1'b1;
    end else begin : g_body
      assign newer = slot_r[gi - 1];
      assign newer_used = used_r[gi - 1];
    end
    if (gi == DEPTH - 1) begin : g_tail
      assign older = 8'h00;
      assign older_used = 1'b0;
    end else begin : g_next
      assign older = slot_r[gi + 1];
      assign older_used = used_r[gi + 1];
    end
    // push with pop swaps the head only, the rest stays put
    assign slot_nxt[gi] = (push && (!pop || gi == 0)) ? newer :
                          (pop && !push) ? older : slot_r[gi];
    assign used_nxt[gi] = (push && (!pop || gi == 0)) ? newer_used :
                          (pop && !push) ? older_used : used_r[gi];
  end
endgenerate

// one process owns every entry so each bit has a single driver
always @(posedge clk_sys) begin
  if (sys_rst || cls) begin
    for (si = 0; si < DEPTH; si = si + 1) begin
      slot_r[si] <= 8'h00;
    end
    used_r <= {DEPTH{1'b0}};
  end else begin
    for (si = 0; si < DEPTH; si = si + 1) begin
      slot_r[si] <= slot_nxt[si];
    end
    used_r <= used_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// admit and exclude lists
always @(posedge clk_sys) begin
  if (sys_rst || preset) begin
    admit_r <= `SER_ADMIT_RST;
    excl_r <= `SER_EXCL_RST;
  end else if (sel && op == `SER_OP_Q_ADMIT_WR) begin
    admit_r <= wdata;
  end else if (sel && op == `SER_OP_Q_EXCL_WR) begin
    excl_r <= wdata;
  end
end

assign rdata = (op == `SER_OP_Q_NEXT) ? {8'h00, slot_r[0]} :
               (op == `SER_OP_Q_ADMIT_RD) ? admit_r :
               (op == `SER_OP_Q_EXCL_RD) ? excl_r : 16'h0000;

endmodule // ser_errq
`default_nettype wire

// >>> logic/ser_group.v
`default_nettype none
`include "ser_defines.vh"
module ser_group #(
  parameter [15:0] VALID_MASK = `SER_FULL_MASK
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [15:0] cond_in,
  input wire preset,
  input wire cls,
  input wire sel,
  input wire [2:0] op,
  input wire [15:0] wdata,
  output wire [15:0] rdata,
  output wire summary
);

reg [15:0] prev_r;
reg [15:0] rise_r;
reg [15:0] fall_r;
reg [15:0] enable_r;
reg [15:0] event_r;
reg [15:0] event_nxt;
wire [15:0] cond_live;
wire [15:0] hits;
wire wr;

////////////////////////////////////////////////////////////////////////////////
// live conditions, unused bits forced low so they never latch
assign cond_live = cond_in & VALID_MASK;
assign hits = (rise_r & cond_live & ~prev_r) |
              (fall_r & ~cond_live & prev_r);
assign wr = sel;

// event latch: a new hit beats a read clear so no event is lost
always @* begin
  event_nxt = event_r;
  if (sel && op == `SER_OP_EV_RD) begin
    event_nxt = `SER_EVENT_RST;
  end
  if (cls) begin
    event_nxt = `SER_EVENT_RST;
  end
  event_nxt = (event_nxt | hits) & VALID_MASK;
end

////////////////////////////////////////////////////////////////////////////////
// filters, mask and event storage
always @(posedge clk_sys) begin
  if (sys_rst) begin
    prev_r <= cond_live; // capture at reset so no false edge follows release
    rise_r <= VALID_MASK;
    fall_r <= `SER_FALL_RST;
    enable_r <= `SER_ENABLE_RST;
    event_r <= `SER_EVENT_RST;
  end else begin
    prev_r <= cond_live;
    event_r <= event_nxt; // preset leaves events alone
    if (preset) begin
      rise_r <= VALID_MASK;
      fall_r <= `SER_FALL_RST;
      enable_r <= `SER_ENABLE_RST;
    end else if (wr) begin
      case (op)
        `SER_OP_EN_WR: begin
          enable_r <= wdata & VALID_MASK;
        end
        `SER_OP_RISE_WR: begin
          rise_r <= wdata & VALID_MASK;
        end
        `SER_OP_FALL_WR: begin
          fall_r <= wdata & VALID_MASK;
        end
        default: begin
          enable_r <= enable_r;
        end
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// read mux; the top registers it, condition read has no side effect
assign rdata = (op == `SER_OP_EV_RD) ? event_r :
               (op == `SER_OP_EN_RD) ? enable_r :
               (op == `SER_OP_RISE_RD) ? rise_r :
               (op == `SER_OP_FALL_RD) ? fall_r :
               (op == `SER_OP_COND_RD) ? cond_live : 16'h0000;
assign summary = |(event_r & enable_r);

endmodule // ser_group
`default_nettype wire

// >>> logic/ser_status_bank.v
`default_nettype none
`include "ser_defines.vh"
module ser_status_bank #(
  parameter QUEUE_DEPTH = 8
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire relay_delay_flag,
  input wire awaiting_fire_flag,
  input wire awaiting_enable_layer_flag,
  input wire idle_flag,
  input wire [15:0] trig_cond,
  input wire [15:0] arm_cond,
  input wire [15:0] seq_cond,
  input wire err_valid,
  input wire [7:0] err_code,
  input wire cmd_valid,
  input wire [2:0] cmd_sel,
  input wire [2:0] cmd_op,
  input wire [15:0] cmd_wdata,
  output wire rsp_valid,
  output wire [15:0] rsp_data,
  output wire [3:0] summary,
  output wire errq_empty
);

reg [15:0] oper_cond;
reg rsp_valid_r;
reg [15:0] rsp_data_r;
reg [15:0] rsp_nxt;
wire [15:0] grp_cond [0:3];
wire [15:0] grp_rdata [0:3];
wire [15:0] q_rdata;
wire preset;
wire cls;
wire q_sel;
reg is_read;
wire [3:0] grp_sel;
genvar gi;

////////////////////////////////////////////////////////////////////////////////
// operation conditions placed at their bit weights
always @* begin
  oper_cond = 16'h0000;
  oper_cond[`SER_OPER_SETTLE_BIT] = relay_delay_flag;
  oper_cond[`SER_OPER_FIRE_BIT] = awaiting_fire_flag;
  oper_cond[`SER_OPER_ENABLE_BIT] = awaiting_enable_layer_flag;
  oper_cond[`SER_OPER_IDLE_BIT] = idle_flag;
end

assign grp_cond[0] = oper_cond;
assign grp_cond[1] = trig_cond;
assign grp_cond[2] = arm_cond;
assign grp_cond[3] = seq_cond;

// global commands; selector 7 (no doubtful group) is simply ignored
assign preset = cmd_valid && cmd_sel == `SER_SEL_PRESET;
assign cls = cmd_valid && cmd_sel == `SER_SEL_CLS;
assign q_sel = cmd_valid && cmd_sel == `SER_SEL_ERRQ;

// group strobes decoded once so each register set sees only its own
assign grp_sel[0] = cmd_valid && cmd_sel == `SER_SEL_OPER;
assign grp_sel[1] = cmd_valid && cmd_sel == `SER_SEL_TRIG;
assign grp_sel[2] = cmd_valid && cmd_sel == `SER_SEL_ARM;
assign grp_sel[3] = cmd_valid && cmd_sel == `SER_SEL_SEQ;

////////////////////////////////////////////////////////////////////////////////
// one register set per group, same logic, different implemented masks
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_grp
    ser_group #(
      .VALID_MASK((gi == 0) ? `SER_OPER_MASK : `SER_FULL_MASK)
    ) u_grp (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .cond_in(grp_cond[gi]),
      .preset(preset),
      .cls(cls),
      .sel(grp_sel[gi]),
      .op(cmd_op),
      .wdata(cmd_wdata),
      .rdata(grp_rdata[gi]),
      .summary(summary[gi])
    );
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// error queue
ser_errq #(
  .DEPTH(QUEUE_DEPTH)
) u_errq (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .err_valid(err_valid),
  .err_code(err_code),
  .cls(cls),
  .preset(preset),
  .sel(q_sel),
  .op(cmd_op),
  .wdata(cmd_wdata),
  .rdata(q_rdata),
  .empty(errq_empty)
);

////////////////////////////////////////////////////////////////////////////////
// answer only to queries; writes and global commands give no answer
always @* begin
  is_read = 1'b0;
  case (cmd_sel)
    `SER_SEL_OPER, `SER_SEL_TRIG, `SER_SEL_ARM, `SER_SEL_SEQ: begin
      case (cmd_op)
        `SER_OP_EV_RD: begin
          is_read = 1'b1;
        end
        `SER_OP_EN_RD: begin
          is_read = 1'b1;
        end
        `SER_OP_RISE_RD: begin
          is_read = 1'b1;
        end
        `SER_OP_FALL_RD: begin
          is_read = 1'b1;
        end
        `SER_OP_COND_RD: begin
          is_read = 1'b1;
        end
        default: begin
          is_read = 1'b0; // enable, rise and fall writes are silent
        end
      endcase
    end
    `SER_SEL_ERRQ: begin
      case (cmd_op)
        `SER_OP_Q_NEXT: begin
          is_read = 1'b1;
        end
        `SER_OP_Q_ADMIT_RD: begin
          is_read = 1'b1;
        end
        `SER_OP_Q_EXCL_RD: begin
          is_read = 1'b1;
        end
        default: begin
          is_read = 1'b0; // list writes and spare codes are silent
        end
      endcase
    end
    `SER_SEL_PRESET: begin
      is_read = 1'b0;
    end
    `SER_SEL_CLS: begin
      is_read = 1'b0;
    end
    default: begin
      is_read = 1'b0; // spare selector answers nothing
    end
  endcase
end

always @* begin
  case (cmd_sel)
    `SER_SEL_OPER: begin
      rsp_nxt = grp_rdata[0];
    end
    `SER_SEL_TRIG: begin
      rsp_nxt = grp_rdata[1];
    end
    `SER_SEL_ARM: begin
      rsp_nxt = grp_rdata[2];
    end
    `SER_SEL_SEQ: begin
      rsp_nxt = grp_rdata[3];
    end
    `SER_SEL_ERRQ: begin
      rsp_nxt = q_rdata;
    end
    default: begin
      rsp_nxt = 16'h0000;
    end
  endcase
end

// registered answer, value taken before the read clears the register
always @(posedge clk_sys) begin
  if (sys_rst) begin
    rsp_valid_r <= 1'b0;
    rsp_data_r <= 16'h0000;
  end else begin
    rsp_valid_r <= cmd_valid && is_read;
    if (cmd_valid && is_read) begin
      rsp_data_r <= rsp_nxt;
    end
  end
end

assign rsp_valid = rsp_valid_r;
assign rsp_data = rsp_data_r;

endmodule // ser_status_bank
`default_nettype wire

// >>> verification/ser_chk_sva.sv
`default_nettype none
module ser_chk #(parameter QUEUE_DEPTH = 8) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic relay_delay_flag,
  input wire logic awaiting_fire_flag,
  input wire logic awaiting_enable_layer_flag,
  input wire logic idle_flag,
  input wire logic [15:0] trig_cond,
  input wire logic [15:0] arm_cond,
  input wire logic [15:0] seq_cond,
  input wire logic err_valid,
  input wire logic [7:0] err_code,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_sel,
  input wire logic [2:0] cmd_op,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [3:0] summary,
  input wire logic errq_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  // live operation conditions at their bit weights
  wire logic [15:0] op_cond;
  wire logic rd;
  assign op_cond = {5'h00, idle_flag, 3'h0, awaiting_enable_layer_flag,
    awaiting_fire_flag, 3'h0, relay_delay_flag, 1'h0};
  // group read: even op codes and the condition query
  assign rd = cmd_valid && cmd_sel < 3'h4 && (!cmd_op[0] || cmd_op == 3'h7);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  property p_rd; rd |=> rsp_valid; endproperty
  a_rd: assert property (p_rd) else $error("read gave no answer");
  property p_wr; cmd_valid && cmd_sel < 3'h4 && !rd |=> !rsp_valid; endproperty
  a_wr: assert property (p_wr) else $error("write gave an answer");
  property p_quiet; !cmd_valid |=> !rsp_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without command");
  property p_mask; rd && cmd_sel == 3'h0 |=> (rsp_data & 16'hFB9D) == 16'h0000; endproperty
  a_mask: assert property (p_mask) else $error("unused operation bit set");
  property p_cond; rd && cmd_sel == 3'h0 && cmd_op == 3'h7 |=> rsp_data == $past(op_cond);
  endproperty
  a_cond: assert property (p_cond) else $error("condition not live");
  property p_clr; rd && cmd_sel == 3'h0 && cmd_op == 3'h0 && $stable(op_cond) |=> !summary[0];
  endproperty
  a_clr: assert property (p_clr) else $error("summary after event read");
  property p_hold; summary[0] && !cmd_valid |=> summary[0]; endproperty
  a_hold: assert property (p_hold) else $error("event dropped by itself");
  property p_cls; cmd_valid && cmd_sel == 3'h6 && !err_valid |=> errq_empty; endproperty
  a_cls: assert property (p_cls) else $error("queue kept after clear");
  property p_rst; disable iff (1'b0) sys_rst |=> summary == 4'h0 && !rsp_valid && errq_empty;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule // ser_chk
bind ser_status_bank ser_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk_u (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .relay_delay_flag(relay_delay_flag), .idle_flag(idle_flag),
  .awaiting_fire_flag(awaiting_fire_flag), .awaiting_enable_layer_flag(awaiting_enable_layer_flag),
  .trig_cond(trig_cond), .arm_cond(arm_cond), .seq_cond(seq_cond), .err_valid(err_valid),
  .err_code(err_code), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel), .cmd_op(cmd_op),
  .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .summary(summary),
  .errq_empty(errq_empty));
`default_nettype wire

// >>> verification/ser_host.sv
`default_nettype none
module ser_host (
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic [2:0] cmd_sel,
  output logic [2:0] cmd_op,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_sel = 3'h7;
    cmd_op = 3'h0;
    cmd_wdata = 16'h0000;
  end
  // one command per call; answer stands one cycle after the take
  task go(input logic [2:0] s, input logic [2:0] o, input logic [15:0] w,
    output logic [15:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_sel = s;
    cmd_op = o;
    cmd_wdata = w;
    @(negedge clk_sys);
    d = rsp_valid ? rsp_data : 16'hDEAD; // answer stands only this cycle
    cmd_valid = 1'b0;
    cmd_wdata = ~w; // released data must not look still valid
  endtask
endmodule // ser_host
`default_nettype wire

// >>> verification/test_status_event_register_groups.sv
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected %0t: got %h want %h", $time, a, b); end end
module test_status_event_register_groups;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] fl = 4'h0;
  logic [15:0] gc [1:3] = '{16'h0000, 16'h0000, 16'h0000};
  logic err_valid = 1'b0;
  logic [7:0] err_code = 8'h00;
  logic [15:0] d;
  logic [15:0] m;
  logic [15:0] wt [4] = '{16'h0002, 16'h0020, 16'h0040, 16'h0400};
  wire logic cmd_valid, rsp_valid, errq_empty;
  wire logic [2:0] cmd_sel, cmd_op;
  wire logic [15:0] cmd_wdata, rsp_data;
  wire logic [3:0] summary;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  ser_status_bank #(.QUEUE_DEPTH(8)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .relay_delay_flag(fl[0]), .awaiting_fire_flag(fl[1]), .awaiting_enable_layer_flag(fl[2]),
    .idle_flag(fl[3]), .trig_cond(gc[1]), .arm_cond(gc[2]), .seq_cond(gc[3]),
    .err_valid(err_valid), .err_code(err_code), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
    .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .summary(summary), .errq_empty(errq_empty));
  ser_host host_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_sel(cmd_sel),
    .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  ////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t(input logic [2:0] s, input logic [2:0] o, input logic [15:0] w);
    host_u.go(s, o, w, d);
  endtask
  // error source pulse, code scrambled once released
  task push(input logic [7:0] c);
    @(negedge clk_sys);
    err_valid = 1'b1;
    err_code = c;
    @(negedge clk_sys);
    err_valid = 1'b0;
    err_code = ~c;
  endtask
  initial forever #5 clk_sys = ~clk_sys;
  // hang guard, the run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int g = 0; g < 4; g++) begin
      m = (g == 0) ? 16'h0462 : 16'hFFFF;
      t(g[2:0], 3'h0, 16'h0000); `CHK(d, 16'h0000)
      t(g[2:0], 3'h2, 16'h0000); `CHK(d, 16'h0000)
      t(g[2:0], 3'h4, 16'h0000); `CHK(d, m)
      t(g[2:0], 3'h6, 16'h0000); `CHK(d, 16'h0000)
    end
    t(3'h0, 3'h1, 16'hFFFF);
    t(3'h0, 3'h2, 16'h0000); `CHK(d, 16'h0462)
    // raise each operation condition in turn, earlier ones left high
    for (int i = 0; i < 4; i++) begin
      fl[i] = 1'b1;
      t(3'h0, 3'h0, 16'h0000); `CHK(d, wt[i])
    end
    t(3'h0, 3'h7, 16'h0000); `CHK(d, 16'h0462)
    t(3'h0, 3'h0, 16'h0000); `CHK(d, 16'h0000)
    t(3'h0, 3'h3, 16'h0000);
    t(3'h0, 3'h5, 16'hFFFF);
    fl = 4'h0;
    t(3'h0, 3'h7, 16'h0000); `CHK(d, 16'h0000)
    `CHK(summary[0], 1'b1)
    t(3'h0, 3'h1, 16'h0000); `CHK(summary[0], 1'b0)
    fl = 4'h1;
    t(3'h5, 3'h0, 16'h0000);
    t(3'h0, 3'h4, 16'h0000); `CHK(d, 16'h0462)
    t(3'h0, 3'h0, 16'h0000); `CHK(d, 16'h0462)
    for (int g = 1; g < 4; g++) gc[g] = 16'hA5C3 >> g;
    for (int g = 1; g < 4; g++) begin
      t(g[2:0], 3'h7, 16'h0000); `CHK(d, 16'hA5C3 >> g)
      t(g[2:0], 3'h0, 16'h0000); `CHK(d, 16'hA5C3 >> g)
    end
    for (int g = 1; g < 4; g++) gc[g] = 16'hFFFF;
    for (int g = 1; g < 4; g++) t(g[2:0], 3'h1, 16'hFFFF);
    `CHK(summary, 4'hE)
    t(3'h7, 3'h0, 16'h0000); `CHK(d, 16'hDEAD)
    t(3'h6, 3'h0, 16'h0000);
    `CHK(summary, 4'h0)
    for (int g = 0; g < 4; g++) begin
      t(g[2:0], 3'h0, 16'h0000); `CHK(d, 16'h0000)
    end
    // queue: newest first, exclusion map over the low nibble
    push(8'h13);
    push(8'h25);
    t(3'h4, 3'h0, 16'h0000); `CHK(d, 16'h0025)
    t(3'h4, 3'h0, 16'h0000); `CHK(d, 16'h0013)
    `CHK(errq_empty, 1'b1)
    t(3'h4, 3'h3, 16'h0008);
    push(8'h03);
    push(8'h04);
    t(3'h4, 3'h0, 16'h0000); `CHK(d, 16'h0004)
    t(3'h4, 3'h0, 16'h0000); `CHK(d, 16'h0000)
    t(3'h4, 3'h4, 16'h0000); `CHK(d, 16'h0008)
    t(3'h4, 3'h2, 16'h0000); `CHK(d, 16'hFFFF)
    t(3'h4, 3'h1, 16'h0020);
    push(8'h06);
    `CHK(errq_empty, 1'b1)
    push(8'h05);
    `CHK(errq_empty, 1'b0)
    t(3'h6, 3'h0, 16'h0000); `CHK(errq_empty, 1'b1)
    wrap_up();
  end
endmodule // test_status_event_register_groups
`default_nettype wire
